// >>> rtl/nbh_pkg.sv
/*
 * nbh_pkg: shared constants and types for the nand bus host controller.
 * assumes a 10 MHz aclk and a 32-bit axi4-lite register port.
 */
package nbh_pkg;

    // clock and bus timing, in ns as specified; cycle counts derive from them
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_SETUP_NS    = 20;   // strobe-to-latch setup
    localparam int T_PULSE_NS    = 25;   // write/read strobe low time
    localparam int T_HOLD_NS     = 10;   // latch hold after strobe rise

    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(ns_to_cyc(T_SETUP_NS));
    localparam logic [CNT_W-1:0] PULSE_CYC = CNT_W'(ns_to_cyc(T_PULSE_NS));
    localparam logic [CNT_W-1:0] HOLD_CYC  = CNT_W'(ns_to_cyc(T_HOLD_NS));

    // register map (byte addresses)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_COLUMN = 4'h4;
    localparam logic [3:0] REG_ROW    = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hC;

    // ctrl fields
    localparam int CTRL_KIND_LSB = 0;
    localparam int CTRL_TGT_BIT  = 2;
    localparam int CTRL_HOLD_BIT = 3;
    localparam int CTRL_BYTE_LSB = 8;
    // row fields: page in low bits, block above
    localparam int ROW_PAGE_LSB  = 0;
    localparam int ROW_BLOCK_LSB = 6;
    // status fields
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_RB_LSB     = 1;
    localparam int ST_REFUSE_BIT = 3;
    localparam int ST_AERR_BIT   = 4;
    localparam int ST_RD_LSB     = 8;

    // address geometry
    localparam int COL_W        = 12;
    localparam int PAGE_W       = 6;
    localparam int BLOCK_W      = 19;
    localparam int ADDR_CYCLES  = 5;
    localparam logic [COL_W-1:0] COL_LAST = 12'h083F;  // last existing byte offset
    localparam logic [2:0] ADDR_LAST_IDX  = 3'h4;

    // commands that may be issued while the target is busy
    localparam logic [7:0] CMD_STATUS    = 8'h70;
    localparam logic [7:0] CMD_MP_STATUS = 8'h78;
    localparam logic [7:0] CMD_RESET     = 8'hFF;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {K_CMD, K_ADDR, K_WDATA, K_RDATA} nbh_kind_e;

    typedef struct packed {
        logic [7:0] byte_val;
        logic       hold_select;
        logic       target;
        nbh_kind_e  kind;
    } nbh_op_s;

    // everything driven onto the flash bus
    typedef struct packed {
        logic [1:0] chip_select_n;   // [0] primary, [1] secondary
        logic       command_latch;
        logic       address_latch;
        logic       write_strobe_n;
        logic       read_strobe_n;
        logic [7:0] io_out;
        logic       io_oe;
    } nbh_pins_s;

    localparam nbh_pins_s PINS_IDLE = '{chip_select_n: 2'h3, command_latch: 1'b0,
        address_latch: 1'b0, write_strobe_n: 1'b1, read_strobe_n: 1'b1,
        io_out: 8'h00, io_oe: 1'b0};

endpackage : nbh_pkg

// >>> rtl/nbh_addr_pack.sv
/*
 * nbh_addr_pack: slices a column/page/block address into the five
 * address bytes and flags addresses the flash cannot take.
 * assumes the caller walks index 0..4 in order.
 */
`timescale 1ns/1ns
`default_nettype none

module nbh_addr_pack
    import nbh_pkg::*;
#(
    parameter bit DUAL_DIE = 1'b1
)(
    input  wire logic [COL_W-1:0]   column_field,
    input  wire logic [PAGE_W-1:0]  page_field,
    input  wire logic [BLOCK_W-1:0] block_field,
    input  wire logic [2:0]         index,
    output logic [7:0]              addr_byte,
    output logic                    addr_err
);

    wire logic column_top_bit   = column_field[COL_W-1];
    wire logic die_select_bit   = DUAL_DIE ? block_field[18] : 1'b0;
    wire logic col_past_end     = column_field > COL_LAST;
    wire logic spare_bits_dirty = column_top_bit && (column_field[10:6] != 5'h0_0);

    // unassigned lines are forced low; the die bit only in dual-die builds
    always_comb
    begin
        case (index)
            3'h0:    addr_byte = column_field[7:0];
            3'h1:    addr_byte = {4'h0, column_field[11:8]};
            3'h2:    addr_byte = {block_field[7:6], page_field};
            3'h3:    addr_byte = block_field[15:8];
            3'h4:    addr_byte = {5'h0_0, die_select_bit, block_field[17:16]};
            default: addr_byte = 8'h00;
        endcase
    end

    // out-of-page offsets and dirty spare bits both refuse the sequence
    assign addr_err = col_past_end || spare_bits_dirty;

    second_hi_a: assert property (@(index) (index == 3'h1) |-> (addr_byte[7:4] == 4'h0))
        else $error("second address byte has upper nibble set");
    fifth_hi_a: assert property (@(index) (index == 3'h4) |-> (addr_byte[7:3] == 5'h0_0))
        else $error("fifth address byte has unused lines set");

endmodule : nbh_addr_pack

`default_nettype wire

// >>> rtl/nbh_host_ctrl.sv
/*
 * nbh_host_ctrl: host-side controller that drives a nand flash over its
 * multiplexed 8-bit bus, ordered by software through axi4-lite registers.
 * assumes flash pins are sampled synchronously to aclk and the io wire is
 * resolved outside from io_out/io_oe.
 */
// Notes on behaviour
// - commands, addresses and data share the one 8-bit bus, told apart by latch strobes
// - a full address is sent as five consecutive address cycles
// - first byte column 7..0; second column 11..8, upper nibble low
// - column offsets above 2111 are never sent
// - with the top column bit set, column bits 10..6 must be zero
// - fifth byte block 17..16, die bit on line 2, other lines low
// - while flash is busy the host may deselect it and free the bus
// - command latches on strobe rise with select low, address latch low, command latch high
// - command latch high marks command cycle, address latch high marks address cycle
// - a transaction is command, then address cycles, then data cycles
// - data latches on strobe rise with select and both latches low, not busy
// - during address cycles unassigned lines are driven low
`timescale 1ns/1ns
`default_nettype none

module nbh_host_ctrl
    import nbh_pkg::*;
#(
    parameter bit DUAL_DIE = 1'b1
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output nbh_pins_s        flash_pins,
    input  wire logic [7:0]  io_in,
    input  wire logic [1:0]  ready_busy_n
);

    typedef enum {S_IDLE, S_SETUP, S_PULSE, S_HOLD} nbh_state_e;

    function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
            if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
        return r;
    endfunction : merge_strb

    // ---------------- axi4-lite slave ----------------
    logic        aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [3:0]  awaddr_q, araddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0]  wstrb_q;
    logic [1:0]  bresp_q, rresp_q;

    wire logic aw_fire = s_axi_awvalid && awready_q;
    wire logic w_fire  = s_axi_wvalid && wready_q;
    wire logic wr_do   = aw_have_q && w_have_q && !bvalid_q;
    wire logic ar_fire = s_axi_arvalid && arready_q;
    wire logic wr_map  = (awaddr_q == REG_CTRL) || (awaddr_q == REG_COLUMN) ||
                         (awaddr_q == REG_ROW) || (awaddr_q == REG_STATUS);

    // ready is a one-cycle pulse offered only while no item is parked
    // the answer waits for both halves, so aw and w may arrive in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn) begin
            {aw_have_q, w_have_q, awready_q, wready_q, bvalid_q} <= 5'h0_0;
            awaddr_q <= 4'h0; wdata_q <= 32'h0000_0000; wstrb_q <= 4'h0; bresp_q <= RESP_OKAY;
        end else begin
            awready_q <= s_axi_awvalid && !aw_have_q && !awready_q;
            wready_q  <= s_axi_wvalid && !w_have_q && !wready_q;
            if (aw_fire) begin aw_have_q <= 1'b1; awaddr_q <= s_axi_awaddr; end
            if (w_fire) begin w_have_q <= 1'b1; wdata_q <= s_axi_wdata; wstrb_q <= s_axi_wstrb; end
            if (wr_do) begin
                aw_have_q <= 1'b0; w_have_q <= 1'b0; bvalid_q <= 1'b1;
                bresp_q   <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) bvalid_q <= 1'b0;
        end
    end

    // ---------------- software registers ----------------
    logic [COL_W-1:0]          column_q;
    logic [PAGE_W+BLOCK_W-1:0] row_q;
    logic                      refused_q;
    logic [7:0]                rd_byte_q;
    nbh_state_e                state_q;
    nbh_op_s                   op_q;
    logic [CNT_W-1:0]          cnt_q;
    logic [2:0]                idx_q;
    nbh_pins_s                 pin_q;

    wire logic [31:0] col_word = merge_strb({20'h0_0000, column_q}, wdata_q, wstrb_q);
    wire logic [31:0] row_word = merge_strb({7'h00, row_q}, wdata_q, wstrb_q);
    wire nbh_op_s     new_op   = '{byte_val: wdata_q[CTRL_BYTE_LSB +: 8], hold_select: wdata_q[CTRL_HOLD_BIT],
                                   target: wdata_q[CTRL_TGT_BIT], kind: nbh_kind_e'(wdata_q[CTRL_KIND_LSB +: 2])};

    always_ff @(posedge aclk)
    begin
        if (!aresetn) begin
            column_q <= 12'h000; row_q <= 25'h000_0000;
        end else if (wr_do && awaddr_q == REG_COLUMN) column_q <= col_word[COL_W-1:0];
        else if (wr_do && awaddr_q == REG_ROW) row_q <= row_word[PAGE_W+BLOCK_W-1:0];
    end

    // ---------------- address byte source ----------------
    logic [7:0] addr_byte;
    logic       addr_err;
    wire  logic [2:0] idx_nx = (state_q == S_IDLE) ? 3'h0 : idx_q + 3'h1;

    nbh_addr_pack #(.DUAL_DIE(DUAL_DIE)) u_addr (
        .column_field (column_q),
        .page_field   (row_q[ROW_PAGE_LSB +: PAGE_W]),
        .block_field  (row_q[ROW_BLOCK_LSB +: BLOCK_W]),
        .index        (idx_nx),
        .addr_byte    (addr_byte),
        .addr_err     (addr_err)
    );

    // ---------------- launch decision ----------------
    // each order moves one cycle kind; software strings command, address and
    // data orders into a transaction, so the engine never guesses what follows
    wire logic launch    = wr_do && (awaddr_q == REG_CTRL) && (state_q == S_IDLE);
    wire logic tgt_ready = ready_busy_n[new_op.target];
    // only the three busy-safe commands may go to a busy target
    wire logic busy_safe = (new_op.kind == K_CMD) && ((new_op.byte_val == CMD_STATUS) ||
                           (new_op.byte_val == CMD_MP_STATUS) || (new_op.byte_val == CMD_RESET));
    wire logic accept    = (tgt_ready || busy_safe) &&
                           !((new_op.kind == K_ADDR) && addr_err);
    wire logic refuse    = (wr_do && awaddr_q == REG_CTRL && !(launch && accept));
    wire logic is_write  = new_op.kind != K_RDATA;
    wire logic cyc_end   = cnt_q == '0;
    wire logic more_addr = (op_q.kind == K_ADDR) && (idx_q != ADDR_LAST_IDX);
    wire logic rf_clear  = wr_do && (awaddr_q == REG_STATUS) && wstrb_q[0] && wdata_q[ST_REFUSE_BIT];

    // sticky refusal flag; a new refusal outranks a clear in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn) refused_q <= 1'b0;
        else if (refuse) refused_q <= 1'b1;
        else if (rf_clear) refused_q <= 1'b0;
    end

    // ---------------- bus cycle engine ----------------
    // setup -> strobe low -> strobe high (latch edge) -> hold, then next byte or idle
    always_ff @(posedge aclk)
    begin
        if (!aresetn) begin
            state_q <= S_IDLE; pin_q <= PINS_IDLE; cnt_q <= '0; idx_q <= 3'h0;
            op_q <= '{byte_val: 8'h00, hold_select: 1'b0, target: 1'b0, kind: K_CMD}; rd_byte_q <= 8'h00;
        end else begin
            case (state_q)
                S_IDLE:
                    if (launch && accept) begin
                        op_q <= new_op; idx_q <= 3'h0; cnt_q <= SETUP_CYC - 1'b1; state_q <= S_SETUP;
                        pin_q.chip_select_n <= new_op.target ? 2'h1 : 2'h2;
                        pin_q.command_latch <= new_op.kind == K_CMD;
                        pin_q.address_latch <= new_op.kind == K_ADDR;
                        pin_q.io_out <= (new_op.kind == K_ADDR) ? addr_byte : new_op.byte_val;
                        pin_q.io_oe  <= is_write;
                    end
                S_SETUP:
                    if (cyc_end) begin
                        state_q <= S_PULSE; cnt_q <= PULSE_CYC - 1'b1;
                        if (op_q.kind == K_RDATA) pin_q.read_strobe_n <= 1'b0;
                        else pin_q.write_strobe_n <= 1'b0;
                    end else cnt_q <= cnt_q - 1'b1;
                S_PULSE:
                    if (cyc_end) begin
                        state_q <= S_HOLD; cnt_q <= HOLD_CYC - 1'b1;
                        pin_q.write_strobe_n <= 1'b1;
                        pin_q.read_strobe_n  <= 1'b1;
                        if (op_q.kind == K_RDATA) rd_byte_q <= io_in;
                    end else cnt_q <= cnt_q - 1'b1;
                // the next address byte goes out only after the latch edge, never under it
                S_HOLD:
                    if (!cyc_end) cnt_q <= cnt_q - 1'b1;
                    else if (more_addr) begin
                        idx_q <= idx_nx; pin_q.io_out <= addr_byte;
                        cnt_q <= SETUP_CYC - 1'b1; state_q <= S_SETUP;
                    end else begin
                        state_q <= S_IDLE;
                        pin_q.command_latch <= 1'b0; pin_q.address_latch <= 1'b0;
                        pin_q.io_oe <= 1'b0; pin_q.io_out <= 8'h00;
                        // releasing select frees the bus for other devices
                        if (!op_q.hold_select) pin_q.chip_select_n <= 2'h3;
                    end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ---------------- read channel ----------------
    wire logic [31:0] status_word = {16'h0000, rd_byte_q, 3'h0, addr_err, refused_q,
                                     ready_busy_n, state_q != S_IDLE};
    logic [31:0] rd_mux;
    always_comb
    begin
        case (araddr_q)
            REG_CTRL:   rd_mux = {16'h0000, op_q.byte_val, 4'h0, op_q.hold_select, op_q.target, op_q.kind};
            REG_COLUMN: rd_mux = {20'h0_0000, column_q};
            REG_ROW:    rd_mux = {7'h00, row_q};
            REG_STATUS: rd_mux = status_word;
            default:    rd_mux = 32'h0000_0000;
        endcase
    end
    wire logic rd_map = (araddr_q == REG_CTRL) || (araddr_q == REG_COLUMN) ||
                        (araddr_q == REG_ROW) || (araddr_q == REG_STATUS);
    logic ar_have_q;

    // address is parked one cycle, then data answered from the mux
    always_ff @(posedge aclk)
    begin
        if (!aresetn) begin
            {arready_q, ar_have_q, rvalid_q} <= 3'h0; araddr_q <= 4'h0;
            rdata_q <= 32'h0000_0000; rresp_q <= RESP_OKAY;
        end else begin
            arready_q <= s_axi_arvalid && !ar_have_q && !arready_q && !rvalid_q;
            if (ar_fire) begin ar_have_q <= 1'b1; araddr_q <= s_axi_araddr; end
            if (ar_have_q && !rvalid_q) begin
                rvalid_q <= 1'b1; ar_have_q <= 1'b0; rdata_q <= rd_mux;
                rresp_q  <= rd_map ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) rvalid_q <= 1'b0;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign flash_pins    = pin_q;

    // ---------------- checks ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [2:0] ale_edges_q;   // address latch edges in the current sequence
    always_ff @(posedge aclk)
    begin
        if (!aresetn || state_q == S_IDLE) ale_edges_q <= 3'h0;
        else if ($rose(pin_q.write_strobe_n) && pin_q.address_latch) ale_edges_q <= ale_edges_q + 3'h1;
    end

    sequence strobe_rise; $rose(pin_q.write_strobe_n); endsequence
    sequence addr_done;   state_q == S_HOLD && cyc_end && op_q.kind == K_ADDR && !more_addr; endsequence

    latch_excl_a: assert property (!(pin_q.command_latch && pin_q.address_latch))
        else $error("both latch strobes high");
    cmd_latch_a: assert property (strobe_rise and pin_q.command_latch |->
        !pin_q.address_latch && pin_q.io_oe && pin_q.chip_select_n != 2'h3)
        else $error("command edge without select or driven byte");
    // the count is read one edge after the last hold, before idle clears it
    five_addr_a: assert property (addr_done |=> ale_edges_q == 3'(ADDR_CYCLES))
        else $error("address sequence not five cycles");
    bus_dir_a: assert property (pin_q.io_oe |-> pin_q.read_strobe_n)
        else $error("host drives bus during read strobe");
    busy_gate_a: assert property (launch && !tgt_ready && !busy_safe |=> state_q == S_IDLE && refused_q)
        else $error("byte sent to busy target");
    bad_col_a: assert property (launch && new_op.kind == K_ADDR && addr_err |=> state_q == S_IDLE)
        else $error("out of range column sent");
    release_a: assert property (state_q == S_HOLD && cyc_end && !more_addr && !op_q.hold_select
        |=> pin_q.chip_select_n == 2'h3 && !pin_q.io_oe)
        else $error("select not released after cycle");
    data_latch_a: assert property (strobe_rise and !pin_q.command_latch |->
        pin_q.address_latch || op_q.kind == K_WDATA)
        else $error("write edge with wrong cycle marking");
    // select must stand for the whole byte, or the flash drops into standby mid-cycle
    sel_stand_a: assert property (state_q != S_IDLE |-> pin_q.chip_select_n != 2'h3)
        else $error("select released while a byte is on the bus");
    // a read byte is driven by the flash, so the host keeps its drivers off
    rd_release_a: assert property (op_q.kind == K_RDATA && state_q != S_IDLE |-> !pin_q.io_oe)
        else $error("host drives bus during read byte");

endmodule : nbh_host_ctrl

`default_nettype wire

// >>> tb/nbh_flash_model.sv
/*
 * nbh_flash_model: behavioural flash target on the far side of the host bus.
 * assumes pins are synchronous to aclk and the bench drives busy and rd_byte.
 */
`timescale 1ns/1ns
`default_nettype none

module nbh_flash_model
    import nbh_pkg::*;
(
    input  wire logic       aclk,
    input  wire nbh_pins_s  pins,
    input  wire logic [1:0] busy,
    input  wire logic [7:0] rd_byte,
    output logic [7:0]      io_in,
    output logic [1:0]      ready_busy_n,
    output logic [7:0]      cmd_q,
    output logic [39:0]     addr_q,
    output logic [7:0]      data_q,
    output logic            tgt_q
);
    logic       ws_q;
    logic [7:0] last_q = 8'h00;   // defined from time zero, but the first edge samples the unreset pins, so a released bus shows unknowns until the first read
    // decode of the latch strobes on a write strobe rise; both high latches nothing
    wire [1:0] sel_w  = ~pins.chip_select_n;
    wire       tgt_w  = sel_w[1];
    wire       rise_w = pins.write_strobe_n & ~ws_q & (|sel_w);
    wire       bsy_w  = busy[tgt_w];
    wire       safe_w = pins.io_out inside {CMD_STATUS, CMD_MP_STATUS, CMD_RESET};
    wire       cmd_w  = rise_w & pins.command_latch & ~pins.address_latch & (~bsy_w | safe_w);
    wire       adr_w  = rise_w & pins.address_latch & ~pins.command_latch & ~bsy_w;
    wire       dat_w  = rise_w & ~pins.address_latch & ~pins.command_latch & ~bsy_w;
    // released bus flips every cycle between the last read byte and its complement
    assign io_in        = (!pins.read_strobe_n && |sel_w) ? rd_byte : ~last_q;
    assign ready_busy_n = ~busy;
    // address bytes shift in so the first byte ends up lowest
    always_ff @(posedge aclk)
    begin
        ws_q   <= pins.write_strobe_n;
        last_q <= io_in;
        if (cmd_w) cmd_q <= pins.io_out;
        if (cmd_w) tgt_q <= tgt_w;
        if (adr_w) addr_q <= {pins.io_out, addr_q[39:8]};          // whole page named
        if (dat_w) data_q <= pins.io_out;                          // one combined buffer
    end
endmodule : nbh_flash_model

`default_nettype wire

// >>> tb/nbh_host_ctrl_test.sv
/*
 * nbh_host_ctrl_test: self-checking bench driving the controller over axi4-lite.
 * assumes the flash model beside it and a 10 MHz aclk.
 */
`timescale 1ns/1ns
`default_nettype none

module nbh_host_ctrl_test;
    import nbh_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, seed = 32'h0000_C196, rd_q, rdata;
    logic [1:0] busy = 2'h0, bresp, rresp, br_q, rr_q, rbn;
    logic [7:0] rd_byte = 8'h00, io_in, cmd_q, data_q;
    logic [39:0] addr_q;
    logic awready, wready, bvalid, arready, rvalid, tgt_q;
    nbh_pins_s flash_pins;
    int error_cnt = 0, cmp_count = 0, cyc = 0;

    nbh_host_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_pins(flash_pins),
        .io_in(io_in), .ready_busy_n(rbn));
    nbh_flash_model u_flash (.aclk(aclk), .pins(flash_pins), .busy(busy), .rd_byte(rd_byte), .io_in(io_in),
        .ready_busy_n(rbn), .cmd_q(cmd_q), .addr_q(addr_q), .data_q(data_q), .tgt_q(tgt_q));

    always #50 aclk = ~aclk;
    // hang guard: a few hundred cycles are expected, so this is generous
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            test_done();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // expected five address bytes, first byte lowest
    function automatic logic [39:0] addr_exp(input logic [11:0] c, input logic [5:0] p, input logic [18:0] b);
        return {5'h00, b[18:16], b[15:8], b[7:6], p, 4'h0, c[11:8], c[7:0]};
    endfunction : addr_exp

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // write: address and data offered together, each dropped once taken
    // only the hang guard ends a wait for an answer
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0; br_q = bresp;
    endtask : axw
    task automatic axr(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0; rd_q = rdata; rr_q = rresp;
    endtask : axr
    // launch one order (one bus byte, five for an address) and poll the engine until it is free again
    task automatic op(input logic [1:0] k, input logic t, input logic [7:0] b);
        axw(REG_CTRL, {16'h0000, b, 5'h00, t, k});
        do
        begin
            axr(REG_STATUS);
        end while (rd_q[ST_BUSY_BIT] !== 1'b0);
    endtask : op
    task automatic test_done();
        $display("errors=%0d compares=%0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    initial
    begin
        logic [31:0] r;
        logic [11:0] col;
        logic [5:0]  pg;
        logic [18:0] blk;
        logic [7:0]  lc;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        chk(flash_pins, PINS_IDLE);
        for (int i = 0; i < 4; i++)
        begin
            r = rnd();
            lc = {1'b0, r[6:0]};
            op(2'h0, i[0], lc);
            chk({tgt_q, cmd_q}, {i[0], lc});
            chk(flash_pins.chip_select_n, 2'h3);
        end
        // the largest legal column and the lowest with the top bit set come first, then random ones
        for (int i = 0; i < 6; i++)
        begin
            r = rnd();
            col = (i == 0) ? 12'h083F : (i == 1) ? 12'h0800 : 12'(r % 32'h0000_0840);
            pg = r[17:12];
            blk = 19'(rnd());
            axw(REG_COLUMN, {20'h0_0000, col});
            axw(REG_ROW, {7'h00, blk, pg});
            op(2'h1, 1'b0, 8'h00);
            chk(addr_q, addr_exp(col, pg, blk));
        end
        for (int i = 0; i < 2; i++)
        begin
            axw(REG_COLUMN, (i == 0) ? 32'h0000_0840 : 32'h0000_0FFF);
            op(2'h1, 1'b0, 8'h00);
            chk(addr_q, addr_exp(col, pg, blk));
            chk(rd_q[ST_AERR_BIT -: 2], 2'h3);
            axw(REG_STATUS, 32'h0000_0008);
            axr(REG_STATUS);
            chk(rd_q[ST_REFUSE_BIT], 1'b0);
        end
        busy <= 2'h1;
        op(2'h0, 1'b0, 8'h80);
        chk({rd_q[ST_REFUSE_BIT], rd_q[ST_RB_LSB +: 2], cmd_q}, {1'b1, 2'h2, lc});
        // the three busy-safe orders must still reach a busy target
        for (int i = 0; i < 3; i++)
        begin
            lc = (i == 0) ? CMD_STATUS : (i == 1) ? CMD_MP_STATUS : CMD_RESET;
            op(2'h0, 1'b0, lc);
            chk(cmd_q, lc);
        end
        busy <= 2'h0;
        r = rnd();
        op(2'h2, 1'b0, r[7:0]);
        chk(data_q, r[7:0]);
        rd_byte <= r[15:8];
        op(2'h3, 1'b0, 8'h00);
        chk(rd_q[ST_RD_LSB +: 8], r[15:8]);
        axr(4'h2);
        chk({rr_q, rd_q}, {RESP_SLVERR, 32'h0000_0000});
        axw(4'h6, 32'h0000_0000);
        chk(br_q, RESP_SLVERR);
        test_done();
    end
endmodule : nbh_host_ctrl_test

`default_nettype wire
